/* dv/move_exec_chk.sv */
// Concurrent checks of the bus handshake and execution timing of the move executor.
`timescale 1ns/10ps
`default_nettype none

module move_exec_chk
(
   input wire logic        CLK_I,
   input wire logic        RST_N_I,
   input wire logic        CYC_I,
   input wire logic        STB_I,
   input wire logic        WE_I,
   input wire logic [7:0]  ADR_I,
   input wire logic [3:0]  SEL_I,
   input wire logic [31:0] DAT_I,
   input wire logic [31:0] DAT_O,
   input wire logic        ACK_O,
   input wire logic        BUSY_O
);
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RST_N_I);

   // -------------------------------------------------------------------------
   // Instruction write seen at the acknowledging edge.
   // -------------------------------------------------------------------------
   logic instr_wr;
   logic one_word;
   logic two_word;
   assign instr_wr = ACK_O && WE_I && (ADR_I == move_exec_pkg::OFS_INSTR) && (SEL_I[1:0] == 2'h3);
   assign one_word = (DAT_I[15:10] == move_exec_pkg::OPC_OR) || (DAT_I[15:10] == move_exec_pkg::OPC_MOVE_FILE_OP);
   assign two_word = (DAT_I[15:10] == move_exec_pkg::OPC_PTR) || (DAT_I[15:12] == move_exec_pkg::OPC_MEM_TO_MEM_MOVE);

   // -------------------------------------------------------------------------
   // Properties.
   // -------------------------------------------------------------------------
   sequence s_exec_done;
      ##2 BUSY_O ##[1:4] !BUSY_O;
   endsequence
   sequence s_wait_word2;
      ##1 BUSY_O [*8];
   endsequence
   property p_ack_pulse;
      ACK_O |=> !ACK_O;
   endproperty
   property p_ack_cause;
      ACK_O |-> $past(CYC_I && STB_I);
   endproperty
   property p_ack_bound;
      CYC_I && STB_I && !ACK_O |-> ##[1:8] ACK_O;
   endproperty
   property p_unmapped;
      ACK_O && !WE_I && (ADR_I == 8'h28) |-> DAT_O == 32'h0;
   endproperty
   property p_busy_start;
      instr_wr |-> ##[0:1] BUSY_O;
   endproperty
   property p_one_word;
      instr_wr && one_word |-> s_exec_done;
   endproperty
   property p_two_word;
      instr_wr && two_word |-> s_wait_word2;
   endproperty
   property p_stall;
      $rose(BUSY_O) |-> ##1 !ACK_O [*3];
   endproperty

   a_ack_pulse  : assert property (p_ack_pulse)  else $error("ack longer than one cycle");
   a_ack_cause  : assert property (p_ack_cause)  else $error("ack without request");
   a_ack_bound  : assert property (p_ack_bound)  else $error("request not answered in time");
   a_unmapped   : assert property (p_unmapped)   else $error("unmapped read not zero");
   a_busy_start : assert property (p_busy_start) else $error("busy not raised by instruction");
   a_one_word   : assert property (p_one_word)   else $error("one-word op not one cycle");
   a_two_word   : assert property (p_two_word)   else $error("two-word op not waiting");
   a_stall      : assert property (p_stall)      else $error("access taken during execution");
endmodule

bind move_exec move_exec_chk u_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .CYC_I(CYC_I), .STB_I(STB_I),
   .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .BUSY_O(BUSY_O));

`default_nettype wire

/* dv/move_exec_tb.sv */
// Self-checking bench for the move executor.
`timescale 1ns/10ps
`default_nettype none

module move_exec_tb;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] dat = 32'h0;
   logic [31:0] dat_o;
   logic [31:0] rd;
   logic        ack;
   logic        busy;
   logic [23:0] corner [4] = '{24'hFE8123, 24'h0ABFE8, 24'h000FFF, 24'hFFF000};
   int          err_total = 0;
   int          num_checks = 0;
   int          cycles = 0;
   int          seed = 54439;

   move_exec DUT (.CLK_I(clk), .RST_N_I(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
                  .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack), .BUSY_O(busy));

   always #2 clk = ~clk;

   // -------------------------------------------------------------------------
   // Timeout, report and bus tasks.
   // -------------------------------------------------------------------------
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 60000)
      begin
         err_total = err_total + 1;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      dat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, 4'hF, d);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 4'hF, 32'h0);
      chk(rd, exp);
   endtask

   task automatic mem_wr(input logic [11:0] ad, input logic [7:0] v);
      wr(move_exec_pkg::OFS_MEM_ADDR, {20'h0, ad});
      wr(move_exec_pkg::OFS_MEM_DATA, {24'h0, v});
   endtask

   task automatic mem_chk(input logic [11:0] ad, input logic [7:0] v);
      wr(move_exec_pkg::OFS_MEM_ADDR, {20'h0, ad});
      rdchk(move_exec_pkg::OFS_MEM_DATA, {24'h0, v});
   endtask

   task automatic instr(input logic [15:0] w);
      wr(move_exec_pkg::OFS_INSTR, {16'h0, w});
      repeat (2) @(posedge clk);
      while (busy !== 1'b0) @(posedge clk);
   endtask

   task automatic first(input logic [15:0] w);
      wr(move_exec_pkg::OFS_INSTR, {16'h0, w});
      repeat (12) @(posedge clk);
   endtask

   function automatic logic [11:0] fa(input logic a, input logic e, input logic [7:0] f, input logic [3:0] b,
                                      input logic [11:0] p2);
      if (a)
         return {b, f};
      if (e && f <= 8'h5F)
         return p2 + {4'h0, f};
      return (f < 8'h60) ? {4'h0, f} : {4'hF, f};
   endfunction

   // -------------------------------------------------------------------------
   // Main sequence.
   // -------------------------------------------------------------------------
   initial
   begin
      logic [31:0] rnd;
      logic [7:0]  acc, fv, r, f;
      logic [3:0]  bk;
      logic [11:0] p2, ad, src, dst, k;
      logic [1:0]  st;
      logic        d, a, ext, op;
      logic [7:0]  pofs;
      move_exec_pkg::word_t w;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rdchk(move_exec_pkg::OFS_INSTR, 32'h1);
      for (int i = 1; i < 9; i++)
         rdchk(8'(4 * i), 32'h0);
      wr(8'h28, 32'hFFFFFFFF);
      rdchk(8'h28, 32'h0);
      wr(move_exec_pkg::OFS_ACCUM, 32'h5A);
      wb(1'b1, move_exec_pkg::OFS_ACCUM, 4'hE, 32'hA5);
      rdchk(move_exec_pkg::OFS_ACCUM, 32'h5A);
      for (int i = 0; i < 40; i++)
      begin
         rnd = $random(seed);
         {op, d, a, ext, bk, f} = rnd[15:0];
         if (i < 2)
            {a, ext, f} = {2'b01, i[0] ? 8'h60 : 8'h5F};
         rnd = $random(seed);
         {st, acc, fv, p2} = rnd[29:0];
         wr(move_exec_pkg::OFS_CONFIG, {31'h0, ext});
         wr(move_exec_pkg::OFS_BANK, {28'h0, bk});
         wr(move_exec_pkg::OFS_PTR2, {20'h0, p2});
         ad = fa(a, ext, f, bk, p2);
         mem_wr(ad, fv);
         wr(move_exec_pkg::OFS_ACCUM, {24'h0, acc});
         wr(move_exec_pkg::OFS_STATUS, {30'h0, st});
         if (ad == move_exec_pkg::ACCUM_ADDR)
            fv = acc;
         r = op ? fv : (acc | fv);
         w = '{op ? move_exec_pkg::OPC_MOVE_FILE_OP : move_exec_pkg::OPC_OR, d, a, f};
         instr(w);
         rdchk(move_exec_pkg::OFS_STATUS, {30'h0, r[7], r == 8'h00});
         rdchk(move_exec_pkg::OFS_ACCUM, {24'h0, (d && ad != move_exec_pkg::ACCUM_ADDR) ? acc : r});
         mem_chk(ad, (d || ad == move_exec_pkg::ACCUM_ADDR) ? r : fv);
      end
      for (int i = 0; i < 3; i++)
      begin
         rnd = $random(seed);
         {st, p2, k} = rnd[25:0];
         pofs = move_exec_pkg::OFS_PTR0 + 8'(4 * i);
         wr(pofs, {20'h0, p2});
         wr(move_exec_pkg::OFS_STATUS, {30'h0, st});
         first({move_exec_pkg::OPC_PTR, 2'(i), 4'h0, k[11:8]});
         rdchk(pofs, {20'h0, k[11:8], p2[7:0]});
         instr({move_exec_pkg::OPC_SECOND, move_exec_pkg::PTR_SECOND_SUB, k[7:0]});
         rdchk(pofs, {20'h0, k});
         rdchk(move_exec_pkg::OFS_STATUS, {30'h0, st});
      end
      for (int i = 0; i < 8; i++)
      begin
         rnd = $random(seed);
         {fv, st, src, dst} = {rnd[31:24], rnd[25:24], rnd[23:0]};
         if (i < 4)
            {src, dst} = corner[i]; // Destinations stay on plain memory and the accumulator.
         if (src == dst)
            dst = ~src;
         mem_wr(dst, ~fv);
         mem_wr(src, fv);
         wr(move_exec_pkg::OFS_STATUS, {30'h0, st});
         first({move_exec_pkg::OPC_MEM_TO_MEM_MOVE, src});
         instr({move_exec_pkg::OPC_SECOND, dst});
         mem_chk(dst, fv);
         mem_chk(src, fv);
         rdchk(move_exec_pkg::OFS_STATUS, {30'h0, st});
      end
      wr(move_exec_pkg::OFS_ACCUM, 32'h3C);
      wr(move_exec_pkg::OFS_STATUS, 32'h2);
      instr(16'hF5A5);
      rdchk(move_exec_pkg::OFS_ACCUM, 32'h3C);
      rdchk(move_exec_pkg::OFS_STATUS, 32'h2);
      tally_and_finish();
   end
endmodule

`default_nettype wire

/* src/move_exec.sv */
// Executor for OR-with-file, move-file, pointer literal load and memory-to-memory move.
`timescale 1ns/10ps
`default_nettype none

module move_exec
(
   input  wire logic        CLK_I,
   input  wire logic        RST_N_I,
   input  wire logic        CYC_I,
   input  wire logic        STB_I,
   input  wire logic        WE_I,
   input  wire logic [7:0]  ADR_I,
   input  wire logic [3:0]  SEL_I,
   input  wire logic [31:0] DAT_I,
   output logic      [31:0] DAT_O,
   output logic             ACK_O,
   output logic             BUSY_O
);

   // --------------------------------------------------------------------------
   // State.
   // --------------------------------------------------------------------------
   move_exec_pkg::state_t state_ff, nxt_state;
   move_exec_pkg::kind_t  kind_ff, nxt_kind;
   move_exec_pkg::word_t  word_ff, nxt_word;
   logic [1:0]            q_ff, nxt_q;
   logic                  second_ff, nxt_second;
   logic [11:0]           word2_ff, nxt_word2;
   logic [7:0]            src_ff, nxt_src;
   logic [7:0]            accum_ff, nxt_accum;
   logic [3:0]            bank_ff, nxt_bank;
   logic [1:0]            status_ff, nxt_status;
   logic                  ext_ff, nxt_ext;
   logic [2:0][11:0]      ptr_ff, nxt_ptr;
   logic [11:0]           mem_addr_ff, nxt_mem_addr;
   logic                  ack_ff, nxt_ack;
   logic [31:0]           dat_ff, nxt_dat;
   logic                  busy_ff, nxt_busy;
   logic [7:0]            mem [0:4095];

   logic                  take;
   logic                  instr_wr;
   logic [11:0]           op_addr;
   logic [7:0]            result;
   logic                  mem_we;
   logic [11:0]           mem_wa;
   logic [7:0]            mem_wd;
   move_exec_pkg::word_t  in_word;

   // --------------------------------------------------------------------------
   // Helpers.
   // --------------------------------------------------------------------------
   function automatic logic [11:0] lane_merge(input logic [11:0] old, input logic [31:0] d, input logic [3:0] sel);
      logic [11:0] r;
      r = old;
      if (sel[0])
      begin
         r[7:0] = d[7:0];
      end
      if (sel[1])
      begin
         r[11:8] = d[11:8];
      end
      return r;
   endfunction

   function automatic logic [11:0] file_addr(input logic [7:0] f, input logic a, input logic ext,
                                             input logic [3:0] bank_select_reg, input logic [11:0] base);
      logic [11:0] r;
      if (a)
      begin
         r = {bank_select_reg, f};
      end
      else if (ext && (f <= move_exec_pkg::INDEX_MAX))
      begin
         r = 12'(base + {4'h0, f});
      end
      else if (f < move_exec_pkg::ACCESS_SPLIT)
      begin
         r = {move_exec_pkg::ACCESS_LO_BANK, f};
      end
      else
      begin
         r = {move_exec_pkg::ACCESS_HI_BANK, f};
      end
      return r;
   endfunction

   function automatic logic [7:0] mem_read(input logic [11:0] addr);
      logic [7:0] r;
      if (addr == move_exec_pkg::ACCUM_ADDR)
      begin
         r = accum_ff;
      end
      else
      begin
         r = mem[addr];
      end
      return r;
   endfunction

   function automatic move_exec_pkg::kind_t decode(input move_exec_pkg::word_t w);
      move_exec_pkg::kind_t k;
      if (w.opc == move_exec_pkg::OPC_OR)
      begin
         k = move_exec_pkg::K_OR;
      end
      else if (w.opc == move_exec_pkg::OPC_MOVE_FILE_OP)
      begin
         k = move_exec_pkg::K_MOVE_FILE_OP;
      end
      else if (w.opc == move_exec_pkg::OPC_PTR)
      begin
         k = move_exec_pkg::K_PTR;
      end
      else if (w.opc[5:2] == move_exec_pkg::OPC_MEM_TO_MEM_MOVE)
      begin
         k = move_exec_pkg::K_MEM_TO_MEM_MOVE;
      end
      else
      begin
         k = move_exec_pkg::K_NOP;
      end
      return k;
   endfunction

   // --------------------------------------------------------------------------
   // Bus decode and operand address.
   // --------------------------------------------------------------------------
   assign take     = CYC_I && STB_I && !ack_ff && (state_ff != move_exec_pkg::ST_EXEC);
   assign instr_wr = take && WE_I && (ADR_I == move_exec_pkg::OFS_INSTR) && (SEL_I[1:0] == 2'h3);
   assign in_word  = move_exec_pkg::word_t'(DAT_I[15:0]);
   assign result   = (kind_ff == move_exec_pkg::K_OR) ? (accum_ff | src_ff) : src_ff;

   always_comb
   begin
      if (kind_ff == move_exec_pkg::K_MEM_TO_MEM_MOVE)
      begin
         op_addr = second_ff ? word2_ff : {word_ff.opc[1:0], word_ff.dest, word_ff.bank, word_ff.file};
      end
      else
      begin
         op_addr = file_addr(word_ff.file, word_ff.bank, ext_ff, bank_ff, ptr_ff[move_exec_pkg::INDEX_PTR]);
      end
   end

   // --------------------------------------------------------------------------
   // Sequencer: one instruction cycle is four clocks, Q1 to Q4.
   // --------------------------------------------------------------------------
   always_comb
   begin
      nxt_state  = state_ff;
      nxt_kind   = kind_ff;
      nxt_word   = word_ff;
      nxt_q      = q_ff;
      nxt_second = second_ff;
      nxt_word2  = word2_ff;
      nxt_src    = src_ff;
      case (state_ff)
         move_exec_pkg::ST_IDLE, move_exec_pkg::ST_WAIT2:
         begin
            if (instr_wr)
            begin
               nxt_state = move_exec_pkg::ST_EXEC;
               nxt_q     = 2'h0;
               if ((state_ff == move_exec_pkg::ST_WAIT2) && (DAT_I[15:12] == move_exec_pkg::OPC_SECOND))
               begin
                  nxt_second = 1'b1;
                  nxt_word2  = DAT_I[11:0];
               end
               else
               begin
                  nxt_second = 1'b0;
                  nxt_word   = in_word;
                  nxt_kind   = decode(in_word);
               end
            end
         end
         move_exec_pkg::ST_EXEC:
         begin
            nxt_q = 2'(q_ff + 2'h1);
            if ((q_ff == move_exec_pkg::Q_READ) && !second_ff)
            begin
               nxt_src = mem_read(op_addr);
            end
            if (q_ff == move_exec_pkg::Q_WRITE)
            begin
               if (!second_ff && ((kind_ff == move_exec_pkg::K_PTR) || (kind_ff == move_exec_pkg::K_MEM_TO_MEM_MOVE)))
               begin
                  nxt_state = move_exec_pkg::ST_WAIT2;
               end
               else
               begin
                  nxt_state = move_exec_pkg::ST_IDLE;
               end
            end
         end
         default:
         begin
            nxt_state = move_exec_pkg::ST_IDLE;
         end
      endcase
   end

   // --------------------------------------------------------------------------
   // Execution results and software register writes.
   // --------------------------------------------------------------------------
   always_comb
   begin
      nxt_accum    = accum_ff;
      nxt_bank     = bank_ff;
      nxt_status   = status_ff;
      nxt_ext      = ext_ff;
      nxt_ptr      = ptr_ff;
      nxt_mem_addr = mem_addr_ff;
      mem_we       = 1'b0;
      mem_wa       = op_addr;
      mem_wd       = result;
      if ((state_ff == move_exec_pkg::ST_EXEC) && (q_ff == move_exec_pkg::Q_WRITE))
      begin
         case (kind_ff)
            move_exec_pkg::K_OR, move_exec_pkg::K_MOVE_FILE_OP:
            begin
               nxt_status[move_exec_pkg::STAT_N_BIT] = result[7];
               nxt_status[move_exec_pkg::STAT_Z_BIT] = (result == 8'h00);
               if (word_ff.dest)
               begin
                  mem_we = 1'b1;
               end
               else
               begin
                  nxt_accum = result;
               end
            end
            move_exec_pkg::K_PTR:
            begin
               if (!(word_ff.dest && word_ff.bank))
               begin
                  if (!second_ff)
                  begin
                     nxt_ptr[{word_ff.dest, word_ff.bank}][11:8] = word_ff.file[3:0];
                  end
                  else if (word2_ff[11:8] == move_exec_pkg::PTR_SECOND_SUB)
                  begin
                     nxt_ptr[{word_ff.dest, word_ff.bank}][7:0] = word2_ff[7:0];
                  end
               end
            end
            move_exec_pkg::K_MEM_TO_MEM_MOVE:
            begin
               mem_we = second_ff;
               mem_wd = src_ff;
            end
            default:
            begin
               mem_we = 1'b0;
            end
         endcase
      end
      else if (take && WE_I && SEL_I[0])
      begin
         case (ADR_I)
            move_exec_pkg::OFS_ACCUM:    nxt_accum  = DAT_I[7:0];
            move_exec_pkg::OFS_BANK:     nxt_bank   = DAT_I[3:0];
            move_exec_pkg::OFS_STATUS:   nxt_status = DAT_I[1:0];
            move_exec_pkg::OFS_CONFIG:   nxt_ext    = DAT_I[move_exec_pkg::CFG_EXT_BIT];
            move_exec_pkg::OFS_PTR0:     nxt_ptr[0] = lane_merge(ptr_ff[0], DAT_I, SEL_I);
            move_exec_pkg::OFS_PTR1:     nxt_ptr[1] = lane_merge(ptr_ff[1], DAT_I, SEL_I);
            move_exec_pkg::OFS_PTR2:     nxt_ptr[2] = lane_merge(ptr_ff[2], DAT_I, SEL_I);
            move_exec_pkg::OFS_MEM_ADDR: nxt_mem_addr = lane_merge(mem_addr_ff, DAT_I, SEL_I);
            move_exec_pkg::OFS_MEM_DATA:
            begin
               mem_we = 1'b1;
               mem_wa = mem_addr_ff;
               mem_wd = DAT_I[7:0];
            end
            default:
            begin
               mem_we = 1'b0;
            end
         endcase
      end
      if (mem_we && (mem_wa == move_exec_pkg::ACCUM_ADDR))
      begin
         nxt_accum = mem_wd;
      end
   end

   // --------------------------------------------------------------------------
   // Bus answer.
   // --------------------------------------------------------------------------
   always_comb
   begin
      nxt_ack  = take;
      nxt_busy = (nxt_state != move_exec_pkg::ST_IDLE);
      nxt_dat  = 32'h00000000;
      if (take && !WE_I)
      begin
         case (ADR_I)
            move_exec_pkg::OFS_INSTR:    nxt_dat = {word_ff, 13'h0000, state_ff};
            move_exec_pkg::OFS_ACCUM:    nxt_dat = {24'h000000, accum_ff};
            move_exec_pkg::OFS_BANK:     nxt_dat = {28'h0000000, bank_ff};
            move_exec_pkg::OFS_STATUS:   nxt_dat = {30'h00000000, status_ff};
            move_exec_pkg::OFS_CONFIG:   nxt_dat = {31'h00000000, ext_ff};
            move_exec_pkg::OFS_PTR0:     nxt_dat = {20'h00000, ptr_ff[0]};
            move_exec_pkg::OFS_PTR1:     nxt_dat = {20'h00000, ptr_ff[1]};
            move_exec_pkg::OFS_PTR2:     nxt_dat = {20'h00000, ptr_ff[2]};
            move_exec_pkg::OFS_MEM_ADDR: nxt_dat = {20'h00000, mem_addr_ff};
            move_exec_pkg::OFS_MEM_DATA: nxt_dat = {24'h000000, mem_read(mem_addr_ff)};
            default:                     nxt_dat = 32'h00000000;
         endcase
      end
   end

   // --------------------------------------------------------------------------
   // Registers.
   // --------------------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         state_ff    <= move_exec_pkg::ST_IDLE;
         kind_ff     <= move_exec_pkg::K_NOP;
         word_ff     <= '0;
         q_ff        <= 2'h0;
         second_ff   <= 1'b0;
         word2_ff    <= 12'h000;
         src_ff      <= 8'h00;
         accum_ff    <= move_exec_pkg::ACCUM_RST;
         bank_ff     <= move_exec_pkg::BANK_RST;
         status_ff   <= move_exec_pkg::STATUS_RST;
         ext_ff      <= move_exec_pkg::CONFIG_RST;
         ptr_ff      <= {3{move_exec_pkg::PTR_RST}};
         mem_addr_ff <= 12'h000;
         ack_ff      <= 1'b0;
         dat_ff      <= 32'h00000000;
         busy_ff     <= 1'b0;
      end
      else
      begin
         state_ff    <= nxt_state;
         kind_ff     <= nxt_kind;
         word_ff     <= nxt_word;
         q_ff        <= nxt_q;
         second_ff   <= nxt_second;
         word2_ff    <= nxt_word2;
         src_ff      <= nxt_src;
         accum_ff    <= nxt_accum;
         bank_ff     <= nxt_bank;
         status_ff   <= nxt_status;
         ext_ff      <= nxt_ext;
         ptr_ff      <= nxt_ptr;
         mem_addr_ff <= nxt_mem_addr;
         ack_ff      <= nxt_ack;
         dat_ff      <= nxt_dat;
         busy_ff     <= nxt_busy;
      end
   end

   always_ff @(posedge CLK_I)
   begin
      if (mem_we && (mem_wa != move_exec_pkg::ACCUM_ADDR))
      begin
         mem[mem_wa] <= mem_wd;
      end
   end

   assign DAT_O  = dat_ff;
   assign ACK_O  = ack_ff;
   assign BUSY_O = busy_ff;

endmodule

`default_nettype wire

/* src/move_exec_pkg.sv */
// Constants, types and register map for the OR, move and pointer-load executor.
// -----------------------------------------------------------------------------
// What this block does
// - OR accumulator with file register, result to destination, set negative and zero.
// - OR decoded from one word with upper bits 000100, then d, a, f; one cycle.
// - Destination bit 0 writes the accumulator, 1 writes back the file register.
// - The 8-bit file field picks any byte of a 256-byte bank.
// - Bank bit 0 picks the access bank, 1 takes upper address from bank select.
// - Extended set on, bank bit 0, file at most 95: indexed literal offset address.
// - Move-file, upper bits 010100, copies file to destination, sets negative and zero.
// - Pointer load puts a 12-bit literal into pointer 0 to 2, high part first.
// - Pointer load words are 111000 ff kkkk and 11110000 kkkkkkkk; flags unchanged.
// - Memory move: 1100 source word, 1111 destination word, read then write, no flags.
// - Memory move addresses reach all 4096 bytes without the bank select.
// - Memory move may take the accumulator's data location as source or destination.
// -----------------------------------------------------------------------------
package move_exec_pkg;

   // --------------------------------------------------------------------------
   // Register offsets (byte addresses on the bus).
   // --------------------------------------------------------------------------
   localparam logic [7:0]  OFS_INSTR    = 8'h00;
   localparam logic [7:0]  OFS_ACCUM    = 8'h04;
   localparam logic [7:0]  OFS_BANK     = 8'h08;
   localparam logic [7:0]  OFS_STATUS   = 8'h0C;
   localparam logic [7:0]  OFS_CONFIG   = 8'h10;
   localparam logic [7:0]  OFS_PTR0     = 8'h14;
   localparam logic [7:0]  OFS_PTR1     = 8'h18;
   localparam logic [7:0]  OFS_PTR2     = 8'h1C;
   localparam logic [7:0]  OFS_MEM_ADDR = 8'h20;
   localparam logic [7:0]  OFS_MEM_DATA = 8'h24;

   // --------------------------------------------------------------------------
   // Field positions, encodings and data-space layout.
   // --------------------------------------------------------------------------
   localparam int unsigned STAT_Z_BIT     = 0;
   localparam int unsigned STAT_N_BIT     = 1;
   localparam int unsigned CFG_EXT_BIT    = 0;
   localparam logic [5:0]  OPC_OR         = 6'h04;
   localparam logic [5:0]  OPC_MOVE_FILE_OP       = 6'h14;
   localparam logic [5:0]  OPC_PTR        = 6'h38;
   localparam logic [3:0]  OPC_MEM_TO_MEM_MOVE      = 4'hC;
   localparam logic [3:0]  OPC_SECOND     = 4'hF;
   localparam logic [3:0]  PTR_SECOND_SUB = 4'h0;
   localparam logic [11:0] ACCUM_ADDR     = 12'hFE8;
   localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;
   localparam logic [7:0]  INDEX_MAX      = 8'h5F;
   localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
   localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;
   localparam logic [1:0]  INDEX_PTR      = 2'h2;
   localparam logic [1:0]  Q_READ         = 2'h1;
   localparam logic [1:0]  Q_WRITE        = 2'h3;

   // --------------------------------------------------------------------------
   // Reset values.
   // --------------------------------------------------------------------------
   localparam logic [7:0]  ACCUM_RST  = 8'h00;
   localparam logic [3:0]  BANK_RST   = 4'h0;
   localparam logic [1:0]  STATUS_RST = 2'h0;
   localparam logic        CONFIG_RST = 1'b0;
   localparam logic [11:0] PTR_RST    = 12'h000;

   // --------------------------------------------------------------------------
   // Types.
   // --------------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_EXEC  = 3'b010,
      ST_WAIT2 = 3'b100
   } state_t;

   typedef enum logic [4:0] {
      K_NOP   = 5'b00001,
      K_OR    = 5'b00010,
      K_MOVE_FILE_OP  = 5'b00100,
      K_PTR   = 5'b01000,
      K_MEM_TO_MEM_MOVE = 5'b10000
   } kind_t;

   typedef struct packed {
      logic [5:0] opc;
      logic       dest;
      logic       bank;
      logic [7:0] file;
   } word_t;

endpackage
